// file: rtl/insn_exec_defines.svh
// Constants for the instruction subset execution unit
`ifndef INSN_EXEC_DEFINES_SVH
`define INSN_EXEC_DEFINES_SVH
`define OP_WIDTH 3
`define OP_CLEAR_ACC 3'h0
`define OP_DEC_FILE 3'h1
`define OP_DEC_SKIP 3'h2
`define OP_INC_SKIP 3'h3
`define OP_BRANCH 3'h4
`define OP_OR_LIT 3'h5
`define OP_NOP 3'h6
`define ACC_RESET 8'h00
`define ZERO_RESET 1'b0
`define PC_RESET 13'h0000
`define PC_LOW_MSB 10
`define LATCH_HI 4
`define LATCH_LO 3
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1
`endif

// file: rtl/insn_exec_pkg.sv
// Types shared by the instruction subset execution unit
package insn_exec_pkg;
  typedef logic [2:0] opcode_t;

  typedef struct packed {
    logic valid;
    opcode_t op;
    logic [6:0] fileAddr;
    logic dest;
    logic [10:0] literal;
  } insn_s;

  typedef struct packed {
    logic write;
    logic [6:0] addr;
    logic [7:0] data;
  } file_write_s;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_FLUSH = 2'b01
  } exec_state_e;
endpackage

// file: rtl/alu_result.sv
// Result and zero detection for the arithmetic subset
`timescale 1ns/1ps
`include "insn_exec_defines.svh"
module alu_result
(
  input wire logic [2:0] op,
  input wire logic [7:0] fileData,
  input wire logic [7:0] acc,
  input wire logic [7:0] literal,
  output logic [7:0] result,
  output logic isZero
);
  wire logic [7:0] decValue;
  wire logic [7:0] incValue;
  assign decValue = fileData - 8'h01;
  assign incValue = fileData + 8'h01;
  assign result = (op == `OP_CLEAR_ACC) ? `ACC_RESET :
                  (op == `OP_INC_SKIP) ? incValue :
                  (op == `OP_OR_LIT) ? (acc | literal) : decValue;
  // Full 8-bit compare, never a carry
  assign isZero = (result == 8'h00);
endmodule

// file: rtl/mcu_instruction_subset_exec.sv
// Execution unit for an accumulator and file-register instruction subset
`timescale 1ns/1ps
`include "insn_exec_defines.svh"
// Summary of operation
// - clear_accumulator_op loads 00h into accumulator and sets zero flag.
// - decrement_file_op subtracts one from file 0..127, updates zero flag.
// - Destination bit 0 writes accumulator, 1 writes the addressed file.
// - decrement_skip_zero_op writes result, no flags; zero result skips next.
// - increment_skip_zero_op adds one, no flags; zero result skips next.
// - Branch loads literal into counter 10:0, latch bits 4:3 into 12:11.
// - Branch takes two cycles; second flushes the fetched instruction.
// - or_literal_accumulator_op ORs 8-bit literal into accumulator, updates zero flag.
module mcu_instruction_subset_exec
(
  input wire logic mclk,
  input wire logic rst,
  input insn_exec_pkg::insn_s insn,
  input wire logic [7:0] fileReadData,
  input wire logic [7:0] upper_address_latch,
  output logic [6:0] fileReadAddr,
  output insn_exec_pkg::file_write_s fileWrite,
  output logic [7:0] acc,
  output logic zeroFlag,
  output logic [12:0] program_counter,
  output logic pcLoad,
  output logic flushing,
  output logic busy
);
  import insn_exec_pkg::*;

  // Shared opcode compare for the per-code decode lines
  function automatic logic op_is(input opcode_t code, input opcode_t want);
    op_is = (code == want);
  endfunction

  exec_state_e state;
  exec_state_e next_state;
  logic [7:0] result;
  logic isZero;

  wire logic execNow;
  wire logic isClear;
  wire logic isDec;
  wire logic isDecSkip;
  wire logic isIncSkip;
  wire logic isBranch;
  wire logic isOr;
  wire logic isFileOp;
  wire logic toFile;
  wire logic toAcc;
  wire logic flagUpdate;
  wire logic skipTaken;
  wire logic [12:0] next_pc;
  wire logic [7:0] next_acc;
  wire logic next_zero;
  wire logic [`OP_NOP-1:0] opHit;
  wire logic writePending;
  wire logic [7:0] fileOperand;
  wire logic flushNext;
  wire logic next_pcLoad;
  wire logic [12:0] next_pcHold;
  wire file_write_s next_fileWrite;

  // Fetched instruction is ignored while the flush cycle runs
  assign execNow = insn.valid && (state == ST_EXEC);

  // One qualified hit per decoded code; codes from no_operation up do nothing
  genvar g;
  generate
    for (g = 0; g < `OP_NOP; g = g + 1)
    begin : g_op_hit
      assign opHit[g] = execNow && op_is(insn.op, opcode_t'(g));
    end
  endgenerate

  assign isClear = opHit[`OP_CLEAR_ACC];
  assign isDec = opHit[`OP_DEC_FILE];
  assign isDecSkip = opHit[`OP_DEC_SKIP];
  assign isIncSkip = opHit[`OP_INC_SKIP];
  assign isBranch = opHit[`OP_BRANCH];
  assign isOr = opHit[`OP_OR_LIT];
  assign isFileOp = isDec || isDecSkip || isIncSkip;

  // File address is combinational so the register file answers in-cycle
  always_comb
  begin
    fileReadAddr = insn.fileAddr;
  end

  // File writes land one edge after the result; bypass the pending write so
  // a back-to-back instruction on the same register sees the new value
  assign writePending = fileWrite.write && (fileWrite.addr == insn.fileAddr);
  assign fileOperand = writePending ? fileWrite.data : fileReadData;

  alu_result u_alu
  (
    .op(insn.op),
    .fileData(fileOperand),
    .acc(acc),
    .literal(insn.literal[7:0]),
    .result(result),
    .isZero(isZero)
  );

  assign toFile = isFileOp && (insn.dest == `DEST_FILE);
  assign toAcc = isClear || isOr || (isFileOp && (insn.dest == `DEST_ACC));
  // Skip instructions leave flags alone
  assign flagUpdate = isClear || isDec || isOr;
  assign skipTaken = (isDecSkip || isIncSkip) && isZero;
  assign next_acc = toAcc ? result : acc;
  assign next_zero = flagUpdate ? isZero : zeroFlag;
  assign next_pc = {upper_address_latch[`LATCH_HI:`LATCH_LO],
                    insn.literal[`PC_LOW_MSB:0]};
  assign next_pcHold = isBranch ? next_pc : program_counter;
  assign next_pcLoad = isBranch;
  assign next_fileWrite = {toFile, insn.fileAddr, result};

  always_comb
  begin
    case (state)
      ST_EXEC:
        next_state = (isBranch || skipTaken) ? ST_FLUSH : ST_EXEC;
      ST_FLUSH:
        next_state = ST_EXEC;
      default:
        next_state = ST_EXEC;
    endcase
  end

  // Flush marks the discarded slot executed as no_operation
  assign flushNext = (next_state == ST_FLUSH);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_EXEC;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      acc <= `ACC_RESET;
    end
    else
    begin
      acc <= next_acc;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      zeroFlag <= `ZERO_RESET;
    end
    else
    begin
      zeroFlag <= next_zero;
    end
  end

  // Pulse, address and data are registered together so they stand as one
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fileWrite <= '0;
    end
    else
    begin
      fileWrite <= next_fileWrite;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      program_counter <= `PC_RESET;
    end
    else
    begin
      program_counter <= next_pcHold;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pcLoad <= 1'b0;
    end
    else
    begin
      pcLoad <= next_pcLoad;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      flushing <= 1'b0;
    end
    else
    begin
      flushing <= flushNext;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'b0;
    end
    else
    begin
      busy <= flushNext;
    end
  end
endmodule

// file: verif/mcu_exec_chk.sv
// Port-level assertions for the instruction subset unit
`timescale 1ns/1ps
`include "insn_exec_defines.svh"
module mcu_exec_chk
(
  input wire logic mclk,
  input wire logic rst,
  input insn_exec_pkg::insn_s insn,
  input wire logic [7:0] fileReadData,
  input wire logic [7:0] upper_address_latch,
  input insn_exec_pkg::file_write_s fileWrite,
  input wire logic [7:0] acc,
  input wire logic zeroFlag,
  input wire logic [12:0] program_counter,
  input wire logic pcLoad,
  input wire logic flushing
);
  import insn_exec_pkg::*;
  // A slot under flush is no instruction at all
  wire take = insn.valid && !flushing;
  wire [2:0] op = insn.op;
  // Register contents as the unit must see them, pending write included
  wire [7:0] fd = (fileWrite.write && fileWrite.addr == insn.fileAddr) ? fileWrite.data
    : fileReadData;
  wire [7:0] lit = insn.literal[7:0];
  wire [1:0] hi = upper_address_latch[4:3];
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_clear_acc: assert property (take && op == `OP_CLEAR_ACC |=> acc == 8'h00 && zeroFlag)
    else $error("clear wrong");
  a_dec_file: assert property (take && op == `OP_DEC_FILE && insn.dest |=> fileWrite.write
    && fileWrite.data == $past(fd) - 8'h01 && fileWrite.addr == $past(insn.fileAddr))
    else $error("decrement wrong");
  a_dest_acc: assert property (take && op == `OP_DEC_FILE && !insn.dest
    |=> !fileWrite.write && acc == $past(fd) - 8'h01) else $error("destination wrong");
  a_dec_skip: assert property (take && op == `OP_DEC_SKIP && fd == 8'h01
    |=> flushing && $stable(zeroFlag) ##1 !flushing) else $error("dec skip wrong");
  a_inc_skip: assert property (take && op == `OP_INC_SKIP && fd == 8'hFF
    |=> flushing && $stable(zeroFlag)) else $error("inc skip wrong");
  a_branch_pc: assert property (take && op == `OP_BRANCH |=> pcLoad
    && program_counter == {$past(hi), $past(insn.literal)}) else $error("branch target wrong");
  a_branch_flush: assert property (take && op == `OP_BRANCH
    |=> flushing ##1 !flushing && !pcLoad) else $error("branch length wrong");
  a_or_lit: assert property (take && op == `OP_OR_LIT |=> acc == ($past(acc) | $past(lit))
    && zeroFlag == (acc == 8'h00)) else $error("or literal wrong");
endmodule
bind mcu_instruction_subset_exec mcu_exec_chk chk (.mclk(mclk), .rst(rst), .insn(insn),
  .fileReadData(fileReadData), .upper_address_latch(upper_address_latch),
  .fileWrite(fileWrite), .acc(acc), .zeroFlag(zeroFlag),
  .program_counter(program_counter), .pcLoad(pcLoad), .flushing(flushing));

// file: verif/file_model.sv
// Data register file model on the far side of the unit
`timescale 1ns/1ps
module file_model
(
  input wire logic mclk,
  input wire logic [6:0] rdAddr,
  input insn_exec_pkg::file_write_s wr,
  output logic [7:0] rdData
);
  import insn_exec_pkg::*;
  logic [7:0] mem [128];
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Same-cycle read, as the unit expects
  assign rdData = mem[rdAddr];
  always @(posedge mclk) if (wr.write) mem[wr.addr] <= wr.data;
endmodule

// file: verif/mcu_instruction_subset_exec_tb.sv
// Self-checking bench for the instruction subset unit
`timescale 1ns/1ps
`include "insn_exec_defines.svh"
module mcu_instruction_subset_exec_tb;
  import insn_exec_pkg::*;
  logic mclk = 0, rst = 1, zeroFlag, pcLoad, flushing, busy, eZ = 0, skip, toF;
  insn_s insn = '0;
  logic [7:0] ual = 8'h00, rd, acc, eAcc = 8'h00, r;
  logic [7:0] sh [128];
  logic [6:0] ra;
  file_write_s fw;
  logic [12:0] pc, ePc = 13'h0000;
  logic [15:0] rs = 16'h8E0C;
  int err_count = 0, n_checks = 0;
  initial forever #2.5 mclk = ~mclk;
  mcu_instruction_subset_exec dut (.mclk(mclk), .rst(rst), .insn(insn), .fileReadData(rd),
    .upper_address_latch(ual), .fileReadAddr(ra), .fileWrite(fw), .acc(acc),
    .zeroFlag(zeroFlag), .program_counter(pc), .pcLoad(pcLoad), .flushing(flushing),
    .busy(busy));
  file_model regs (.mclk(mclk), .rdAddr(ra), .wr(fw), .rdData(rd));
  task automatic chk(logic ok);
    n_checks++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: output differs", $time);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] exp_result(opcode_t op, logic [7:0] f, logic [7:0] w,
      logic [7:0] k);
    return op == `OP_CLEAR_ACC ? 8'h00 : op == `OP_OR_LIT ? (w | k) :
      op == `OP_INC_SKIP ? f + 8'h01 : f - 8'h01;
  endfunction
  task automatic step(opcode_t op, logic [6:0] a, logic d, logic [10:0] k);
    r = exp_result(op, sh[a], eAcc, k[7:0]);
    insn <= '{1'b1, op, a, d, k};
    toF = op inside {`OP_DEC_FILE, `OP_DEC_SKIP, `OP_INC_SKIP} && d;
    if (toF) sh[a] = r;
    else if (op <= `OP_INC_SKIP || op == `OP_OR_LIT) eAcc = r;
    if (op <= `OP_DEC_FILE || op == `OP_OR_LIT) eZ = (r == 8'h00);
    if (op == `OP_BRANCH) ePc = {ual[4:3], k};
    skip = op == `OP_BRANCH || (op inside {`OP_DEC_SKIP, `OP_INC_SKIP} && r == 8'h00);
    @(negedge mclk);
    chk(acc === eAcc && zeroFlag === eZ);
    chk(pc === ePc && pcLoad === (op == `OP_BRANCH) && flushing === skip);
    chk(ra === a && busy === skip && fw.write === toF
      && (!toF || (fw.addr === a && fw.data === r)));
    if (skip)
    begin
      // A clear here would show if the slot were not discarded
      insn <= '{1'b1, `OP_CLEAR_ACC, a, 1'b1, 11'h000};
      @(negedge mclk);
      chk(acc === eAcc && zeroFlag === eZ && fw.write === 1'b0
        && flushing === 1'b0 && pcLoad === 1'b0 && busy === 1'b0);
    end
  endtask
  initial
  begin
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (6) @(posedge mclk);
    @(negedge mclk) rst = 0;
    step(`OP_CLEAR_ACC, 7'h05, 1'b0, 11'h000);
    step(`OP_DEC_FILE, 7'h05, 1'b1, 11'h000);
    step(`OP_INC_SKIP, 7'h05, 1'b1, 11'h000);
    step(`OP_INC_SKIP, 7'h7F, 1'b1, 11'h000);
    step(`OP_DEC_SKIP, 7'h7F, 1'b0, 11'h000);
    step(`OP_BRANCH, 7'h00, 1'b0, 11'h7FF);
    step(`OP_OR_LIT, 7'h00, 1'b0, 11'h700);
    repeat (300)
    begin
      rs = lfsr_next(rs);
      ual = rs[15:8];
      step(rs[2:0] == 3'h7 ? `OP_NOP : rs[2:0], rs[9:3], rs[10], {rs[4:0], rs[15:10]});
    end
    end_of_test;
  end
  initial
  begin
    #20000;
    err_count++;
    end_of_test;
  end
endmodule
